// ==== supply_voltage_cmd_status_tb_top.sv ====
`timescale 1ns/1ps
module supply_voltage_cmd_status_tb_top;
  logic               ref_clk_i;              // 250 MHz clock
  logic               resetn_i;               // sync reset, active low
  logic [12:0]        cond;                   // live condition levels
  logic signed [31:0] rb, a0, a1, prog;       // readback, args, drive
  logic               vld, mv, rdy, rv, pol, led;
  logic [31:0]        rd;                     // response value
  svc_pkg::svc_cmd_t  code;                   // command code
  int                 n_errors, comparisons;  // tallies
  always #2 ref_clk_i = ~ref_clk_i;
  svc_host u_host (.clk_i(ref_clk_i), .rdy_i(rdy), .code_o(code), .vld_o(vld),
                   .a0_o(a0), .a1_o(a1), .mv_o(mv));
  svc_core u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(vld),
    .cmd_code_i(code), .cmd_arg0_i(a0), .cmd_arg1_i(a1), .cmd_mv_i(mv), .cond_i(cond),
    .rb_raw_i(rb), .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_data_o(rd),
    .prog_mv_o(prog), .polarity_o(pol), .err_led_o(led));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // query and compare strobe plus value
  task automatic q(input svc_pkg::svc_cmd_t c, input logic [31:0] exp);
    u_host.send(c, 32'sh0, 32'sh0, 1'b1);
    chk({rv, rd}, {1'b1, exp});
  endtask
  // drive outputs settle two edges after the take
  task automatic settle;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
  initial begin
    ref_clk_i = 1'b0;
    resetn_i = 1'b0;
    cond = 13'h0000;
    rb = 32'sh0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    resetn_i = 1'b1;
    q(svc_pkg::SVC_CMD_SET_Q, 32'h0);
    q(svc_pkg::SVC_CMD_CEILING_Q, 32'hea60);
    u_host.send(svc_pkg::SVC_CMD_SETPOINT, 32'sh5, 32'sh0, 1'b0);
    settle();
    chk({1'b0, prog}, 33'h1388);
    q(svc_pkg::SVC_CMD_SET_Q, 32'h1388);
    // ceiling below the setpoint is refused
    u_host.send(svc_pkg::SVC_CMD_CEILING, 32'shfa0, 32'sh0, 1'b1);
    settle();
    chk({32'h0, led}, 33'h1);
    q(svc_pkg::SVC_CMD_CEILING_Q, 32'hea60);
    q(svc_pkg::SVC_CMD_ERR_Q, 32'h7);
    q(svc_pkg::SVC_CMD_LIVE_Q, 32'h0);
    u_host.send(svc_pkg::SVC_CMD_SETPOINT, -32'sh5, 32'sh0, 1'b0);
    settle();
    chk({32'h0, pol}, 33'h1);
    // a held setting stays invisible until the trigger
    u_host.send(svc_pkg::SVC_CMD_HOLD, 32'sh1, 32'sh0, 1'b1);
    u_host.send(svc_pkg::SVC_CMD_SETPOINT, 32'sh7, 32'sh0, 1'b0);
    settle();
    chk({1'b0, prog}, 33'h1388);
    q(svc_pkg::SVC_CMD_SET_Q, 32'hffff_ec78);
    u_host.send(svc_pkg::SVC_CMD_TRIGGER, 32'sh0, 32'sh0, 1'b1);
    q(svc_pkg::SVC_CMD_SET_Q, 32'h1b58);
    chk({32'h0, pol}, 33'h0);
    u_host.send(svc_pkg::SVC_CMD_HOLD, 32'sh0, 32'sh0, 1'b1);
    cond = 13'h0301;
    q(svc_pkg::SVC_CMD_LIVE_Q, 32'h301);
    cond = 13'h0000;
    q(svc_pkg::SVC_CMD_ACC_Q, 32'h301);
    q(svc_pkg::SVC_CMD_ACC_Q, 32'h0);
    cond = 13'h0108;
    q(svc_pkg::SVC_CMD_FAULT_Q, 32'h0);
    cond = 13'h0000;
    u_host.send(svc_pkg::SVC_CMD_MASK, 32'sh1fff, 32'sh0, 1'b1);
    q(svc_pkg::SVC_CMD_MASK_Q, 32'h1fff);
    cond = 13'h0108;
    q(svc_pkg::SVC_CMD_FAULT_Q, 32'h8);
    q(svc_pkg::SVC_CMD_FAULT_Q, 32'h0);
    u_host.send(svc_pkg::SVC_CMD_CAL_EN, 32'sh1, 32'sh0, 1'b1);
    rb = 32'sh3e8;
    u_host.send(svc_pkg::SVC_CMD_CAL_LO, 32'sh0, 32'sh0, 1'b1);
    settle();
    chk({1'b0, prog}, 33'h258);
    rb = 32'sh1388;
    u_host.send(svc_pkg::SVC_CMD_CAL_HI, 32'sh0, 32'sh0, 1'b1);
    settle();
    chk({1'b0, prog}, 33'hdea8);
    u_host.send(svc_pkg::SVC_CMD_CAL_COMP, 32'sh3e8, 32'sh2328, 1'b1);
    chk({32'h0, rdy}, 33'h0);
    u_host.send(svc_pkg::SVC_CMD_CAL_EN, 32'sh0, 32'sh0, 1'b1);
    rb = 32'shdac;
    q(svc_pkg::SVC_CMD_MEAS_Q, 32'h1770);
    // calibration points are refused once calibration mode is off
    u_host.send(svc_pkg::SVC_CMD_CAL_LO, 32'sh0, 32'sh0, 1'b1);
    q(svc_pkg::SVC_CMD_ERR_Q, 32'hc);
    chk({1'b0, prog}, 33'h1b58);
    end_of_test();
  end
endmodule

// ==== svc_core.sv ====
`timescale 1ns/1ps
`include "svc_params.svh"
// voltage programming, readback calibration and condition registers
module svc_core #(
  parameter logic signed [31:0] MODEL_SOFT_VOLTAGE_CEILING_MV = 32'sd60000, // model maximum output
  parameter logic signed [31:0] CAL_LO_MV     = 32'sd600,   // low calibration drive
  parameter logic signed [31:0] CAL_HI_MV     = 32'sd57000  // high calibration drive
) (
  input  wire logic                 ref_clk_i,    // 250 MHz clock
  input  wire logic                 resetn_i,     // sync reset, active low
  input  wire logic                 cmd_valid_i,  // command strobe, one cycle
  input  wire svc_pkg::svc_cmd_t    cmd_code_i,   // decoded command
  input  wire logic signed [31:0]   cmd_arg0_i,   // first argument
  input  wire logic signed [31:0]   cmd_arg1_i,   // second argument
  input  wire logic                 cmd_mv_i,     // arguments are millivolts
  input  wire logic [12:0]          cond_i,       // live condition levels
  input  wire logic signed [31:0]   rb_raw_i,     // raw readback sample
  output logic                      cmd_ready_o,  // commands taken when high
  output logic                      rsp_valid_o,  // response strobe
  output logic [31:0]               rsp_data_o,   // response value
  output logic signed [31:0]        prog_mv_o,    // voltage drive to the output stage
  output logic                      polarity_o,   // user signal for polarity relays
  output logic                      err_led_o     // error indicator
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  logic signed [31:0] ceil_r, ceil_nxt;         // soft ceiling, mV
  logic signed [31:0] set_r, set_nxt;           // active setpoint magnitude, mV
  logic               neg_r, neg_nxt;           // active polarity request
  logic signed [31:0] pend_r, pend_nxt;         // held setpoint
  logic               pneg_r, pneg_nxt;         // held polarity
  logic               pvld_r, pvld_nxt;         // held setting waiting
  logic               hold_r, hold_nxt;         // hold mode on
  logic               calen_r, calen_nxt;       // calibration mode on
  svc_pkg::svc_cal_t  cal_r, cal_nxt;           // calibration drive
  logic signed [31:0] rlo_r, rlo_nxt;           // raw readback at low point
  logic signed [31:0] rhi_r, rhi_nxt;           // raw readback at high point
  logic signed [31:0] vlo_r, vlo_nxt;           // metered low voltage for offset
  logic               sneg_r, sneg_nxt;         // slope sign during division
  logic signed [31:0] slope_r, slope_nxt;       // readback gain, q16
  logic signed [31:0] offs_r, offs_nxt;         // readback offset, mV
  logic [12:0]        mask_r, mask_nxt;         // fault mask
  logic [12:0]        acc_r, acc_nxt;           // accumulated conditions
  logic [12:0]        flt_r, flt_nxt;           // latched faults
  logic [12:0]        prev_r;                   // live vector one cycle ago
  logic               errb_r, errb_nxt;         // programming error condition
  logic [31:0]        ecode_r, ecode_nxt;       // last error number
  logic               rv_r, rv_nxt;             // response strobe
  logic [31:0]        rd_r, rd_nxt;             // response data
  logic signed [31:0] prog_r, prog_nxt;         // drive register
  logic               rdy_r;                    // ready register

  //////////////////////////////////////////////////////////////////////////////
  // combinational helpers
  logic [12:0]        live;                     // live condition vector
  logic               take;                     // command accepted
  logic signed [31:0] a0, a1;                   // arguments in mV
  logic signed [31:0] mag0;                     // magnitude of first argument
  logic signed [63:0] meas_p, offs_p;           // readback products
  logic signed [31:0] dv, dr;                   // calibration spans
  logic               div_start, div_busy, div_done;
  logic [47:0]        div_q;                    // raw slope magnitude
  logic signed [31:0] slope_new;                // signed slope from divider
  logic               is_err;                   // this command raised an error
  logic [31:0]        err_num;                  // its error number

  // live bits follow their inputs; error comes from the latched error
  assign live = (cond_i & `SVC_LIVE_EXT) | {5'h00, errb_r, 7'h00};
  assign take = cmd_valid_i && rdy_r;
  // volts are scaled to millivolts, the default unit
  assign a0   = cmd_mv_i ? cmd_arg0_i : 32'(cmd_arg0_i * `SVC_MV_PER_V);
  assign a1   = cmd_mv_i ? cmd_arg1_i : 32'(cmd_arg1_i * `SVC_MV_PER_V);
  assign mag0 = a0[31] ? -a0 : a0;
  // measured voltage passes through the calibration, never the setpoint
  assign meas_p = rb_raw_i * slope_r;
  assign offs_p = rlo_r * slope_new;
  assign dv   = a1 - a0;
  assign dr   = rhi_r - rlo_r;
  assign div_start = take && cmd_code_i == svc_pkg::SVC_CMD_CAL_COMP && calen_r;
  assign slope_new = sneg_r ? -32'(div_q) : 32'(div_q);

  // slope numerator is the voltage span in q16; the sign is handled apart
  svc_div #(.NW(48), .DW(32)) u_div (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (div_start),
    .num_i     ({16'h0000, (dv[31] ? 16'(-dv) : 16'(dv)), 16'h0000}),
    .den_i     (dr[31] ? 32'(-dr) : 32'(dr)),
    .busy_o    (div_busy),
    .done_o    (div_done),
    .quo_o     (div_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // command decode: setpoint, ceiling, hold, calibration and errors
  always_comb begin
    ceil_nxt  = ceil_r;
    set_nxt   = set_r;
    neg_nxt   = neg_r;
    pend_nxt  = pend_r;
    pneg_nxt  = pneg_r;
    pvld_nxt  = pvld_r;
    hold_nxt  = hold_r;
    calen_nxt = calen_r;
    cal_nxt   = cal_r;
    rlo_nxt   = rlo_r;
    rhi_nxt   = rhi_r;
    vlo_nxt   = vlo_r;
    sneg_nxt  = sneg_r;
    slope_nxt = slope_r;
    offs_nxt  = offs_r;
    mask_nxt  = mask_r;
    is_err    = 1'b0;
    err_num   = `SVC_ERR_NONE;
    if (take) begin
      unique case (cmd_code_i)
        svc_pkg::SVC_CMD_SETPOINT: begin
          if (mag0[31] || mag0 > MODEL_SOFT_VOLTAGE_CEILING_MV) begin
            is_err  = 1'b1;
            err_num = `SVC_ERR_RANGE;
          end else if (mag0 > ceil_r) begin
            is_err  = 1'b1;
            err_num = `SVC_ERR_SOFT;
          end else if (hold_r) begin
            // held values wait; output keeps the old ones
            pend_nxt = mag0;
            pneg_nxt = a0[31];
            pvld_nxt = 1'b1;
          end else begin
            set_nxt = mag0;
            neg_nxt = a0[31];
          end
        end
        svc_pkg::SVC_CMD_CEILING: begin
          if (a0 < 32'sd0 || a0 > MODEL_SOFT_VOLTAGE_CEILING_MV) begin
            is_err  = 1'b1;
            err_num = `SVC_ERR_RANGE;
          end else if (a0 < set_r) begin
            is_err  = 1'b1;
            err_num = `SVC_ERR_CEIL;
          end else begin
            ceil_nxt = a0;
          end
        end
        svc_pkg::SVC_CMD_HOLD: begin
          hold_nxt = (a0 != 32'sd0);
        end
        svc_pkg::SVC_CMD_TRIGGER: begin
          // a ceiling lowered meanwhile cannot be below the active value,
          // but a held value could exceed it; such a value is dropped
          if (pvld_r && pend_r <= ceil_r) begin
            set_nxt = pend_r;
            neg_nxt = pneg_r;
          end
          pvld_nxt = 1'b0;
        end
        svc_pkg::SVC_CMD_CAL_EN: begin
          calen_nxt = (a0 != 32'sd0);
          if (a0 == 32'sd0) begin
            cal_nxt = svc_pkg::SVC_CAL_OFF;
          end
        end
        svc_pkg::SVC_CMD_CAL_LO, svc_pkg::SVC_CMD_CAL_HI, svc_pkg::SVC_CMD_CAL_COMP: begin
          if (!calen_r) begin
            is_err  = 1'b1;
            err_num = `SVC_ERR_CAL;
          end else if (cmd_code_i == svc_pkg::SVC_CMD_CAL_LO) begin
            // a repeat of this command records the settled readback
            cal_nxt = svc_pkg::SVC_CAL_LO;
            rlo_nxt = rb_raw_i;
          end else if (cmd_code_i == svc_pkg::SVC_CMD_CAL_HI) begin
            cal_nxt = svc_pkg::SVC_CAL_HI;
            rhi_nxt = rb_raw_i;
          end else begin
            vlo_nxt  = a0;
            sneg_nxt = dv[31] ^ dr[31];
          end
        end
        svc_pkg::SVC_CMD_MASK: begin
          mask_nxt = a0[12:0];
        end
        default: begin
        end
      endcase
    end
    // store gain and offset once the division has finished
    if (div_done) begin
      slope_nxt = slope_new;
      offs_nxt  = vlo_r - 32'(offs_p >>> `SVC_SLOPE_FRAC);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // condition registers and responses
  always_comb begin
    logic acc_q;
    logic flt_q;
    logic err_q;
    acc_q     = take && cmd_code_i == svc_pkg::SVC_CMD_ACC_Q;
    flt_q     = take && cmd_code_i == svc_pkg::SVC_CMD_FAULT_Q;
    err_q     = take && cmd_code_i == svc_pkg::SVC_CMD_ERR_Q;
    // a new error wins over the error query in the same cycle
    errb_nxt  = is_err ? 1'b1 : (err_q ? 1'b0 : errb_r);
    ecode_nxt = is_err ? err_num : (err_q ? `SVC_ERR_NONE : ecode_r);
    // set wins over clear-on-read for both latching registers
    acc_nxt   = (acc_q ? 13'h0000 : acc_r) | live | {5'h00, is_err, 7'h00};
    if (err_q) begin
      acc_nxt[`SVC_BIT_ERR] = is_err;
    end
    flt_nxt   = (flt_q ? 13'h0000 : flt_r)
              | (live & ~prev_r & mask_r & `SVC_FAULT_OK);
    rv_nxt    = 1'b0;
    rd_nxt    = rd_r;
    if (take) begin
      rv_nxt = 1'b1;
      unique case (cmd_code_i)
        // the register replies are the binary sum of the set bit weights
        svc_pkg::SVC_CMD_LIVE_Q:    rd_nxt = {19'h0, live};
        svc_pkg::SVC_CMD_ACC_Q:     rd_nxt = {19'h0, acc_r};
        svc_pkg::SVC_CMD_FAULT_Q:   rd_nxt = {19'h0, flt_r};
        svc_pkg::SVC_CMD_MASK_Q:    rd_nxt = {19'h0, mask_r};
        svc_pkg::SVC_CMD_ERR_Q:     rd_nxt = ecode_r;
        svc_pkg::SVC_CMD_CEILING_Q: rd_nxt = ceil_r;
        svc_pkg::SVC_CMD_SET_Q:     rd_nxt = neg_r ? -set_r : set_r;
        svc_pkg::SVC_CMD_MEAS_Q:    rd_nxt = 32'(meas_p >>> `SVC_SLOPE_FRAC) + offs_r;
        default:                    rv_nxt = 1'b0;
      endcase
    end
    // calibration points override the setpoint on the output stage
    unique case (cal_r)
      svc_pkg::SVC_CAL_LO: prog_nxt = CAL_LO_MV;
      svc_pkg::SVC_CAL_HI: prog_nxt = CAL_HI_MV;
      svc_pkg::SVC_CAL_OFF: prog_nxt = set_r;
      default:             prog_nxt = set_r;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; updated every cycle regardless of commands
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ceil_r  <= MODEL_SOFT_VOLTAGE_CEILING_MV;
      set_r   <= `SVC_SET_RST;
      neg_r   <= 1'b0;
      pend_r  <= `SVC_SET_RST;
      pneg_r  <= 1'b0;
      pvld_r  <= 1'b0;
      hold_r  <= 1'b0;
      calen_r <= 1'b0;
      cal_r   <= svc_pkg::SVC_CAL_OFF;
      rlo_r   <= 32'sh0000_0000;
      rhi_r   <= 32'sh0000_0000;
      vlo_r   <= 32'sh0000_0000;
      sneg_r  <= 1'b0;
      slope_r <= `SVC_SLOPE_ONE;
      offs_r  <= 32'sh0000_0000;
      mask_r  <= `SVC_MASK_RST;
      acc_r   <= 13'h0000;
      flt_r   <= 13'h0000;
      prev_r  <= 13'h0000;
      errb_r  <= 1'b0;
      ecode_r <= `SVC_ERR_NONE;
      rv_r    <= 1'b0;
      rd_r    <= 32'h0000_0000;
      prog_r  <= `SVC_SET_RST;
      rdy_r   <= 1'b0;
    end else begin
      ceil_r  <= ceil_nxt;
      set_r   <= set_nxt;
      neg_r   <= neg_nxt;
      pend_r  <= pend_nxt;
      pneg_r  <= pneg_nxt;
      pvld_r  <= pvld_nxt;
      hold_r  <= hold_nxt;
      calen_r <= calen_nxt;
      cal_r   <= cal_nxt;
      rlo_r   <= rlo_nxt;
      rhi_r   <= rhi_nxt;
      vlo_r   <= vlo_nxt;
      sneg_r  <= sneg_nxt;
      slope_r <= slope_nxt;
      offs_r  <= offs_nxt;
      mask_r  <= mask_nxt;
      acc_r   <= acc_nxt;
      flt_r   <= flt_nxt;
      prev_r  <= live;
      errb_r  <= errb_nxt;
      ecode_r <= ecode_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      prog_r  <= prog_nxt;
      // busy divider holds off commands; ready drops the cycle it starts
      rdy_r   <= !(div_busy || div_start);
    end
  end

  assign cmd_ready_o = rdy_r;
  assign rsp_valid_o = rv_r;
  assign rsp_data_o  = rd_r;
  assign prog_mv_o   = prog_r;
  assign polarity_o  = neg_r;
  assign err_led_o   = errb_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence ceil_low_s;
    take && cmd_code_i == svc_pkg::SVC_CMD_CEILING && a0 < set_r;
  endsequence
  sequence ceil_kept_s;
    ceil_r == $past(ceil_r) && acc_r[`SVC_BIT_ERR] && err_led_o;
  endsequence
  ceil_reject_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ceil_low_s |=> ceil_kept_s)
    else $error("low ceiling was not rejected");
  set_le_ceil_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    set_r <= ceil_r && ceil_r <= MODEL_SOFT_VOLTAGE_CEILING_MV)
    else $error("setpoint above ceiling");
  neg_polarity_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (take && cmd_code_i == svc_pkg::SVC_CMD_SETPOINT && !hold_r && a0[31] && mag0 <= ceil_r)
    |=> polarity_o ##1 polarity_o || $past(take))
    else $error("negative setpoint without polarity signal");
  hold_keeps_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (hold_r && !(take && cmd_code_i == svc_pkg::SVC_CMD_TRIGGER)) |=> $stable(set_r))
    else $error("held setting took effect early");
  acc_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (take && cmd_code_i == svc_pkg::SVC_CMD_ACC_Q)
    |=> rsp_valid_o && rsp_data_o == {19'h0, $past(acc_r)} && acc_r == $past(live))
    else $error("accumulated read wrong or not cleared");
  fault_rise_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (live[`SVC_BIT_OV] && !prev_r[`SVC_BIT_OV] && mask_r[`SVC_BIT_OV]) |=> flt_r[`SVC_BIT_OV])
    else $error("masked rising condition not latched");
  fault_no_pon_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    flt_r[`SVC_BIT_REM:`SVC_BIT_PON] == 2'b00 && flt_r[`SVC_BIT_UNUSED] == 1'b0)
    else $error("power-up or remote in fault register");
  err_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (take && cmd_code_i == svc_pkg::SVC_CMD_ERR_Q && !is_err)
    |=> !errb_r && !acc_r[`SVC_BIT_ERR] && !live[`SVC_BIT_ERR])
    else $error("error query did not clear error bit");
  mask_reset_a: assert property (@(posedge ref_clk_i)
    $rose(resetn_i) |-> mask_r == 13'h0000 && ceil_r == MODEL_SOFT_VOLTAGE_CEILING_MV)
    else $error("mask or ceiling wrong after reset");
endmodule

// ==== svc_div.sv ====
`timescale 1ns/1ps
`include "svc_params.svh"
// unsigned restoring divider, one quotient bit per clock
module svc_div #(
  parameter int NW = 48,                 // numerator and quotient width
  parameter int DW = 32                  // divisor width
) (
  input  wire logic          ref_clk_i,  // clock
  input  wire logic          resetn_i,   // sync reset, active low
  input  wire logic          start_i,    // one-cycle start pulse
  input  wire logic [NW-1:0] num_i,      // dividend
  input  wire logic [DW-1:0] den_i,      // divisor, zero gives all ones
  output logic               busy_o,     // division in progress
  output logic               done_o,     // one-cycle result pulse
  output logic      [NW-1:0] quo_o       // quotient
);
  logic [NW:0]   rem_r, rem_nxt;         // partial remainder
  logic [NW-1:0] quo_r, quo_nxt;         // quotient shift register
  logic [DW-1:0] den_r, den_nxt;         // captured divisor
  logic [6:0]    cnt_r, cnt_nxt;         // bits still to produce
  logic          done_r, done_nxt;       // result strobe
  logic [NW:0]   shl;                    // shifted remainder

  // next-state: shift in one dividend bit and try a subtraction
  always_comb begin
    rem_nxt  = rem_r;
    quo_nxt  = quo_r;
    den_nxt  = den_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    shl      = {rem_r[NW-1:0], quo_r[NW-1]};
    if (start_i && cnt_r == 7'h00) begin
      rem_nxt = '0;
      quo_nxt = num_i;
      den_nxt = den_i;
      cnt_nxt = 7'(NW);
    end else if (cnt_r != 7'h00) begin
      // compare against the zero-extended divisor
      if (shl >= {{(NW+1-DW){1'b0}}, den_r}) begin
        rem_nxt = shl - {{(NW+1-DW){1'b0}}, den_r};
        quo_nxt = {quo_r[NW-2:0], 1'b1};
      end else begin
        rem_nxt = shl;
        quo_nxt = {quo_r[NW-2:0], 1'b0};
      end
      cnt_nxt  = cnt_r - 7'h01;
      done_nxt = (cnt_r == 7'h01);
    end
  end

  // registers only
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rem_r  <= '0;
      quo_r  <= '0;
      den_r  <= '0;
      cnt_r  <= 7'h00;
      done_r <= 1'b0;
    end else begin
      rem_r  <= rem_nxt;
      quo_r  <= quo_nxt;
      den_r  <= den_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_o = (cnt_r != 7'h00);
  assign done_o = done_r;
  assign quo_o  = quo_r;

  // a started division finishes in a fixed number of cycles
  div_bound_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (start_i && cnt_r == 7'h00) |-> ##49 done_r)
    else $error("divider did not finish on time");
endmodule

// ==== svc_host.sv ====
`timescale 1ns/1ps
// command source in the place of the bus controller
module svc_host (
  input  wire logic          clk_i,   // device clock
  input  wire logic          rdy_i,   // device takes commands
  output svc_pkg::svc_cmd_t  code_o,  // command code
  output logic               vld_o,   // command strobe
  output logic signed [31:0] a0_o,    // first argument
  output logic signed [31:0] a1_o,    // second argument
  output logic               mv_o     // millivolt units
);
  initial begin
    vld_o = 1'b0;
    code_o = svc_pkg::SVC_CMD_LIVE_Q;
    a0_o = 32'sh0;
    a1_o = 32'sh0;
    mv_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // one command: wait for ready, strobe one cycle, release
  task automatic send(input svc_pkg::svc_cmd_t c, input logic signed [31:0] x, y,
                      input logic m);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    while (rdy_i !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    vld_o = 1'b1;
    code_o = c;
    a0_o = x;
    a1_o = y;
    mv_o = m;
    @(posedge clk_i);
    #1;
    vld_o = 1'b0;
    // released argument lines do not keep their value; code and unit lines do
    a0_o = ~x;
    a1_o = ~y;
  endtask
endmodule

// ==== svc_params.svh ====
// What this block does
// - reject bad ceiling, flag error, latch error bit
// - ceiling range zero to model maximum, resets maximum
// - ceiling query returns stored ceiling voltage
// - measured query returns calibrated readback, not setpoint
// - compute derives readback slope and offset, stores
// - high point drives top voltage, records readback
// - low point drives bottom voltage, records readback
// - setpoint in volts or millivolts, drives output
// - negative setpoint asserts user polarity signal
// - setpoint range zero to maximum, resets zero
// - setpoint query returns active, never pending value
// - three condition registers update every cycle
// - register query answers sum of bit weights
// - fixed bit positions for each condition
// - power-up and remote bits excluded from faults
// - every condition but power-up and remote individually maskable for faults
// - error query clears programming error bits
// - accumulated query clears register after answering
// - fault query clears latched faults after answering
// - fault bit sets on masked live rising edge
// - fault mask resets to no conditions
// - live bit follows its condition exactly
// - held settings wait for trigger command
`ifndef SVC_PARAMS_SVH
`define SVC_PARAMS_SVH

// condition register geometry
`define SVC_NBITS        13
`define SVC_BIT_CV       0
`define SVC_BIT_CC       1
`define SVC_BIT_UNUSED   2
`define SVC_BIT_OV       3
`define SVC_BIT_OT       4
`define SVC_BIT_SD       5
`define SVC_BIT_CUTBACK_ACTIVE_FLAG     6
`define SVC_BIT_ERR      7
`define SVC_BIT_PON      8
`define SVC_BIT_REM      9
`define SVC_BIT_ACF      10
`define SVC_BIT_OPF      11
`define SVC_BIT_SENSE_TRIP_FLAG     12
// bits driven from the condition inputs (all but unused and error)
`define SVC_LIVE_EXT     13'h1f7b
// bits that may ever reach the fault register (no power-up, no remote)
`define SVC_FAULT_OK     13'h1cff
`define SVC_MASK_RST     13'h0000

// error numbers
`define SVC_ERR_NONE     32'h0000_0000
`define SVC_ERR_RANGE    32'h0000_0005
`define SVC_ERR_SOFT     32'h0000_0006
`define SVC_ERR_CEIL     32'h0000_0007
`define SVC_ERR_CAL      32'h0000_000c

// value scaling and calibration fixed point
`define SVC_MV_PER_V     32'sd1000
`define SVC_SLOPE_FRAC   16
`define SVC_SLOPE_ONE    32'sh0001_0000
`define SVC_SET_RST      32'sh0000_0000
`define SVC_DIV_CYCLES   48

`endif

// ==== svc_pkg.sv ====
package svc_pkg;
  // decoded commands arriving from the front-end parser
  typedef enum logic [4:0] {
    SVC_CMD_SETPOINT   = 5'h00,
    SVC_CMD_SET_Q      = 5'h01,
    SVC_CMD_CEILING    = 5'h02,
    SVC_CMD_CEILING_Q  = 5'h03,
    SVC_CMD_MEAS_Q     = 5'h04,
    SVC_CMD_CAL_COMP   = 5'h05,
    SVC_CMD_CAL_HI     = 5'h06,
    SVC_CMD_CAL_LO     = 5'h07,
    SVC_CMD_CAL_EN     = 5'h08,
    SVC_CMD_LIVE_Q     = 5'h09,
    SVC_CMD_ACC_Q      = 5'h0a,
    SVC_CMD_FAULT_Q    = 5'h0b,
    SVC_CMD_MASK       = 5'h0c,
    SVC_CMD_MASK_Q     = 5'h0d,
    SVC_CMD_ERR_Q      = 5'h0e,
    SVC_CMD_HOLD       = 5'h0f,
    SVC_CMD_TRIGGER    = 5'h10
  } svc_cmd_t;

  // what the output drive is doing during calibration
  typedef enum logic [1:0] {
    SVC_CAL_OFF = 2'b00,
    SVC_CAL_LO  = 2'b01,
    SVC_CAL_HI  = 2'b10
  } svc_cal_t;
endpackage
